// ===== aperture_cfg_pkg.sv
package aperture_cfg_pkg;

    // --------------------------------------------------------------
    // configuration access carriers
    // --------------------------------------------------------------
    typedef struct packed {
        logic        rd;      // read strobe, one cycle
        logic        wr;      // write strobe, one cycle
        logic [7:0]  dword;   // byte offset, low two bits ignored
        logic [3:0]  be;      // byte enables
        logic [31:0] wdata;   // write data
    } cfg_req_t;

    typedef struct packed {
        logic        valid;   // read answer valid, one cycle
        logic [31:0] rdata;   // read data
    } cfg_rsp_t;

    // --------------------------------------------------------------
    // offsets, fields and reset values
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_LATENCY_TIMER_STUB = 8'h0d;
    localparam logic [7:0] OFS_HEADER_LAYOUT = 8'h0e;
    localparam logic [7:0] OFS_APERTURE_BASE = 8'h10;
    localparam logic [7:0] OFS_SUBSYSTEM_MAKER_CODE = 8'h2c;

    localparam logic [7:0] LATENCY_TIMER_VALUE = 8'h00;
    localparam logic [7:0] HEADER_LAYOUT_VALUE = 8'h00;
    localparam logic [31:0] APERTURE_BASE_RESET = 32'h0000_0008;
    localparam logic [15:0] SUBSYSTEM_MAKER_RESET = 16'h0000;

    localparam int UPPER_LSB = 28;          // base_upper_field 31:28
    localparam int MIDDLE_LSB = 22;         // base_middle_field 27:22
    localparam int MIDDLE_W = 6;
    localparam logic PREFETCHABLE_FLAG = 1'b1;
    localparam logic [1:0] ADDR_TYPE_ANY32 = 2'b00;
    localparam logic MEMORY_SPACE_FLAG = 1'b0;

endpackage

// ===== aperture_decode.sv
`timescale 1ns/1ps
module aperture_decode
    import aperture_cfg_pkg::*;
(
    // base programming
    input wire logic [3:0] base_upper,
    input wire logic [MIDDLE_W-1:0] base_middle,
    input wire logic [MIDDLE_W-1:0] size_mask,
    input wire logic enable,
    // memory address to test
    input wire logic [31:0] mem_addr,
    input wire logic mem_valid,
    // result
    output logic hit
);

    // --------------------------------------------------------------
    // range compare
    // --------------------------------------------------------------
    logic [9:0] base_bits;  // address bits 31:22 of the base
    logic [9:0] cmp_mask;   // bits that take part in the compare

    // masked bits are don't-care, widening the window to the size
    always_comb begin
        base_bits = {base_upper, base_middle & ~size_mask};
        cmp_mask = {4'hf, ~size_mask};
        hit = mem_valid && enable &&
              (((mem_addr[31:22] ^ base_bits) & cmp_mask) == 10'h000);  // RQ10 RQ11
    end

endmodule

// ===== aperture_cfg_regs.sv
`timescale 1ns/1ps
// Function
// RQ1 - latency timer byte reads zero, writes ignored
// RQ2 - header type byte always reads zero
// RQ3 - base bits 31:28 fully read/write
// RQ4 - base bits 27:22 writable unless size-masked
// RQ5 - base bits 21:4 read zero always
// RQ6 - base bit 3 reads one, prefetchable
// RQ7 - aperture reads side-effect free, all bytes
// RQ8 - base bits 2:1 read 00
// RQ9 - base bit 0 reads zero, memory
// RQ10 - translate accesses falling inside aperture range
// RQ11 - aperture accesses gated by misc enable bit
// RQ12 - subsystem maker code writable once only
// RQ13 - aperture enable resets to zero, disabled
// RQ14 - size mask zeroes and locks middle bits
module aperture_cfg_regs
    import aperture_cfg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // configuration access
    input wire cfg_req_t cfg_req,
    output cfg_rsp_t cfg_rsp,
    // settings held elsewhere in the header
    input wire logic [MIDDLE_W-1:0] aperture_size_select,
    input wire logic aperture_access_enable,
    // memory path probe
    input wire logic [31:0] mem_addr,
    input wire logic mem_valid,
    output logic mem_translate,
    // state views
    output logic [31:0] aperture_base,
    output logic [15:0] subsystem_maker_code,
    output logic maker_code_locked
);

    // --------------------------------------------------------------
    // storage
    // --------------------------------------------------------------
    logic [3:0] base_upper_field_r;           // top four base bits
    logic [MIDDLE_W-1:0] base_middle_field_r; // size-dependent bits
    logic [15:0] subsystem_maker_field_r;     // write-once code
    logic maker_locked_r;                     // set by first write
    logic [31:0] rdata_r;                     // read answer data
    logic rvalid_r;                           // read answer strobe

    logic [31:0] base_view;                   // assembled base word
    logic [31:0] dword_view;                  // word at requested offset
    logic [7:0] word_addr;                    // dword-aligned offset
    logic [31:0] wmask;                       // byte enables as bits

    assign word_addr = {cfg_req.dword[7:2], 2'b00};

    // per-byte write mask from the enables
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_wmask
            assign wmask[gi*8 +: 8] = {8{cfg_req.be[gi]}};
        end
    endgenerate

    // --------------------------------------------------------------
    // base register view
    // --------------------------------------------------------------
    // fixed attribute bits are constants, so no storage to corrupt
    always_comb begin
        base_view = 32'h0000_0000;                                  // RQ5
        base_view[31:UPPER_LSB] = base_upper_field_r;               // RQ3
        base_view[27:MIDDLE_LSB] = base_middle_field_r
                                   & ~aperture_size_select;         // RQ4 RQ14
        base_view[3] = PREFETCHABLE_FLAG;                           // RQ6
        base_view[2:1] = ADDR_TYPE_ANY32;                           // RQ8
        base_view[0] = MEMORY_SPACE_FLAG;                           // RQ9
    end

    // --------------------------------------------------------------
    // upper base bits
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            base_upper_field_r <= APERTURE_BASE_RESET[31:UPPER_LSB];
        end else if (cfg_req.wr && word_addr == OFS_APERTURE_BASE && cfg_req.be[3]) begin
            base_upper_field_r <= cfg_req.wdata[31:UPPER_LSB];     // RQ3
        end
    end

    // --------------------------------------------------------------
    // middle base bits
    // --------------------------------------------------------------
    // masked bits keep their old value; they also read zero, so a
    // later size change exposes whatever was stored before it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            base_middle_field_r <= APERTURE_BASE_RESET[27:MIDDLE_LSB];
        end else if (cfg_req.wr && word_addr == OFS_APERTURE_BASE) begin
            // bits 27:24 in byte 3, 23:22 in byte 2
            if (cfg_req.be[3]) begin
                base_middle_field_r[5:2] <= (cfg_req.wdata[27:24] & ~aperture_size_select[5:2])
                    | (base_middle_field_r[5:2] & aperture_size_select[5:2]);  // RQ4 RQ14
            end
            if (cfg_req.be[2]) begin
                base_middle_field_r[1:0] <= (cfg_req.wdata[23:22] & ~aperture_size_select[1:0])
                    | (base_middle_field_r[1:0] & aperture_size_select[1:0]);  // RQ4 RQ14
            end
        end
    end

    // --------------------------------------------------------------
    // subsystem maker code, write once
    // --------------------------------------------------------------
    // any write touching either byte locks the whole field
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            subsystem_maker_field_r <= SUBSYSTEM_MAKER_RESET;
            maker_locked_r <= 1'b0;
        end else if (cfg_req.wr && word_addr == OFS_SUBSYSTEM_MAKER_CODE
                     && (|cfg_req.be[1:0]) && !maker_locked_r) begin
            subsystem_maker_field_r <= (cfg_req.wdata[15:0] & wmask[15:0])
                | (subsystem_maker_field_r & ~wmask[15:0]);         // RQ12
            maker_locked_r <= 1'b1;                                 // RQ12
        end
    end

    // --------------------------------------------------------------
    // read mux
    // --------------------------------------------------------------
    // reads have no side effect and return full words; the byte
    // enables only matter to the requester
    always_comb begin
        unique case (word_addr)
            8'h0c: begin
                // latency timer at byte 1, header layout at byte 2
                dword_view = {8'h00, HEADER_LAYOUT_VALUE,
                              LATENCY_TIMER_VALUE, 8'h00};          // RQ1 RQ2
            end
            OFS_APERTURE_BASE: begin
                dword_view = base_view;                             // RQ7
            end
            OFS_SUBSYSTEM_MAKER_CODE: begin
                dword_view = {16'h0000, subsystem_maker_field_r};
            end
            default: begin
                // other offsets belong to neighbouring logic
                dword_view = 32'h0000_0000;
            end
        endcase
    end

    // one-cycle registered read answer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 32'h0000_0000;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= cfg_req.rd;
            if (cfg_req.rd) begin
                rdata_r <= dword_view;
            end
        end
    end

    assign cfg_rsp.valid = rvalid_r;
    assign cfg_rsp.rdata = rdata_r;

    // --------------------------------------------------------------
    // aperture range decode
    // --------------------------------------------------------------
    // the enable comes from the misc register, reset there to zero
    aperture_decode u_decode (
        .base_upper(base_upper_field_r),
        .base_middle(base_middle_field_r),
        .size_mask(aperture_size_select),
        .enable(aperture_access_enable),  // RQ11 RQ13
        .mem_addr(mem_addr),
        .mem_valid(mem_valid),
        .hit(mem_translate)
    );

    // --------------------------------------------------------------
    // state views
    // --------------------------------------------------------------
    assign aperture_base = base_view;
    assign subsystem_maker_code = subsystem_maker_field_r;
    assign maker_code_locked = maker_locked_r;

endmodule

// ===== aperture_cfg_checker.sv
`timescale 1ns/1ps
module aperture_cfg_checker
    import aperture_cfg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // configuration access
    input wire cfg_req_t cfg_req,
    input wire cfg_rsp_t cfg_rsp,
    // settings and memory probe
    input wire logic [MIDDLE_W-1:0] aperture_size_select,
    input wire logic aperture_access_enable,
    input wire logic [31:0] mem_addr,
    input wire logic mem_valid,
    input wire logic mem_translate,
    // state views
    input wire logic [31:0] aperture_base,
    input wire logic [15:0] subsystem_maker_code,
    input wire logic maker_code_locked
);
    // ----------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // lane bits dropped, as the bus ignores them
    wire logic sel_hdr = cfg_req.dword[7:2] == OFS_HEADER_LAYOUT[7:2];
    wire logic sel_base = cfg_req.dword[7:2] == OFS_APERTURE_BASE[7:2];
    wire logic sel_code = cfg_req.dword[7:2] == OFS_SUBSYSTEM_MAKER_CODE[7:2];
    // masked middle bits never take part in the range match
    wire logic [5:0] mid_diff = (mem_addr[27:22] ^ aperture_base[27:22]) & ~aperture_size_select;
    wire logic in_range = (mem_addr[31:28] == aperture_base[31:28]) && (mid_diff == 6'h0);
    // ----------------------------------------------------------
    // assertions
    // ----------------------------------------------------------
    chk_read_answer: assert property (
        cfg_rsp.valid == $past(cfg_req.rd)) else $error("read answer not one cycle after request");
    chk_stub_bytes: assert property (
        cfg_req.rd && sel_hdr |=> cfg_rsp.rdata[23:8] == 16'h0) else $error("stub bytes not zero");
    chk_low_zero: assert property (
        aperture_base[21:4] == 18'h0) else $error("base low bits not zero");
    chk_prefetch_one: assert property (
        aperture_base[3] == PREFETCHABLE_FLAG) else $error("prefetch flag lost");
    chk_type_space: assert property (
        aperture_base[2:0] == 3'h0) else $error("type or space bits wrong");
    chk_mask_zero: assert property (
        (aperture_base[27:22] & aperture_size_select) == 6'h0) else $error("masked bit reads one");
    chk_upper_write: assert property (
        cfg_req.wr && sel_base && cfg_req.be[3] |=> aperture_base[31:28] == $past(cfg_req.wdata[31:28]))
        else $error("upper base bits not written");
    chk_base_read: assert property (
        cfg_req.rd && sel_base |=> cfg_rsp.rdata == $past(aperture_base)) else $error("base read wrong");
    chk_code_frozen: assert property (
        maker_code_locked |=> $stable(subsystem_maker_code)) else $error("locked code changed");
    chk_lock_set: assert property (
        cfg_req.wr && sel_code && |cfg_req.be[1:0] |=> maker_code_locked) else $error("code not locked");
    chk_translate_hit: assert property (
        mem_translate == (mem_valid && aperture_access_enable && in_range)) else $error("translate wrong");
    chk_gate_off: assert property (
        !aperture_access_enable |-> !mem_translate) else $error("translate while disabled");
    // main scenarios reached
    cover property (cfg_req.rd ##1 cfg_rsp.valid);
    cover property ($rose(maker_code_locked));
    cover property (mem_translate);
endmodule

bind aperture_cfg_regs aperture_cfg_checker chk (.clk(clk), .arst_n(arst_n), .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp), .aperture_size_select(aperture_size_select), .mem_addr(mem_addr),
    .aperture_access_enable(aperture_access_enable), .mem_valid(mem_valid),
    .mem_translate(mem_translate), .aperture_base(aperture_base),
    .subsystem_maker_code(subsystem_maker_code), .maker_code_locked(maker_code_locked));

// ===== cfg_host_model.sv
`timescale 1ns/1ps
module cfg_host_model
    import aperture_cfg_pkg::*;
(
    // clock
    input wire logic clk,
    // configuration access
    output cfg_req_t cfg_req,
    input wire cfg_rsp_t cfg_rsp
);
    initial cfg_req = '0;
    // one-cycle write; data inverted once released so stale values never match
    task automatic wr(input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk); #1;
        cfg_req = '{rd: 1'b0, wr: 1'b1, dword: ofs, be: be, wdata: d};
        @(posedge clk); #1;
        cfg_req.wr = 1'b0;
        cfg_req.wdata = ~d;
    endtask
    // one-cycle read; a missing answer comes back unknown
    task automatic rd(input logic [7:0] ofs, output logic [31:0] d);
        @(posedge clk); #1;
        cfg_req.rd = 1'b1;
        cfg_req.dword = ofs;
        @(posedge clk); #1;
        cfg_req.rd = 1'b0;
        d = (cfg_rsp.valid === 1'b1) ? cfg_rsp.rdata : 'x;
    endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import aperture_cfg_pkg::*;
    // ----------------------------------------------------------
    // signals and bookkeeping
    // ----------------------------------------------------------
    typedef struct packed {logic [7:0] ofs; logic [3:0] be; logic [31:0] wd;
        logic [5:0] mask; logic [31:0] exp;} row_t;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] size_sel = 6'h0;
    logic ap_en = 1'b0;
    logic [31:0] mem_addr = 32'h0;
    logic mem_valid = 1'b0;
    logic mem_translate, locked;
    logic [31:0] ap_base, rd_data;
    logic [15:0] code;
    cfg_req_t cfg_req;
    cfg_rsp_t cfg_rsp;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    // write then read back the same place
    row_t rows [8] = '{'{8'h0c, 4'hf, 32'hffffffff, 6'h00, 32'h00000000},
        '{8'h10, 4'hf, 32'hffffffff, 6'h00, 32'hffc00008}, '{8'h10, 4'hf, 32'h0, 6'h00, 32'h8},
        '{8'h10, 4'hf, 32'hffffffff, 6'h3f, 32'hf0000008}, '{8'h10, 4'h3, 32'h0, 6'h3f, 32'hf0000008},
        '{8'h10, 4'hf, 32'hffffffff, 6'h15, 32'hfa800008}, '{8'h10, 4'h0, 32'h0, 6'h00, 32'hfa800008},
        '{8'h20, 4'hf, 32'hffffffff, 6'h00, 32'h00000000}};
    always #2 clk = ~clk;
    cfg_host_model host (.clk(clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));
    aperture_cfg_regs dut (.clk(clk), .arst_n(arst_n), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
        .aperture_size_select(size_sel), .aperture_access_enable(ap_en), .mem_addr(mem_addr),
        .mem_valid(mem_valid), .mem_translate(mem_translate), .aperture_base(ap_base),
        .subsystem_maker_code(code), .maker_code_locked(locked));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // combinational probe, settled one step later
    task automatic probe(input logic [31:0] a, input logic v, input logic en, input logic exp);
        mem_addr = a;
        mem_valid = v;
        ap_en = en;
        #1 check({31'h0, mem_translate}, {31'h0, exp});
    endtask
    // hang guard, far above the fifty-odd cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            results();
        end
    end
    // ----------------------------------------------------------
    // sequence
    // ----------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        #1 arst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            size_sel = rows[i].mask;
            host.wr(rows[i].ofs, rows[i].be, rows[i].wd);
            host.rd(rows[i].ofs, rd_data);
            check(rd_data, rows[i].exp);
        end
        $display("table done");
        probe(32'hfabffff0, 1'b1, 1'b1, 1'b1);
        probe(32'hfac00000, 1'b1, 1'b1, 1'b0);
        probe(32'hfa800000, 1'b1, 1'b0, 1'b0);
        probe(32'hfa800000, 1'b0, 1'b1, 1'b0);
        size_sel = 6'h01;
        probe(32'hfac00000, 1'b1, 1'b1, 1'b1);
        $display("translate done");
        host.wr(OFS_SUBSYSTEM_MAKER_CODE, 4'h1, 32'h00001234);
        host.wr(OFS_SUBSYSTEM_MAKER_CODE, 4'h3, 32'h0000abcd);
        host.rd(OFS_SUBSYSTEM_MAKER_CODE, rd_data);
        check(rd_data, 32'h00000034);
        check({31'h0, locked}, 32'h1);
        $display("code lock done");
        arst_n = 1'b0;
        repeat (2) @(posedge clk);
        check(ap_base, APERTURE_BASE_RESET);
        check({15'h0, code, locked}, 32'h0);
        #1 arst_n = 1'b1;
        host.rd(OFS_APERTURE_BASE, rd_data);
        check(rd_data, APERTURE_BASE_RESET);
        $display("reset done");
        results();
    end
endmodule
